// file: rtl/pin_io_pkg.sv
// pin_io_pkg: register map, field layout, reset values and timing of the pin i/o control block
// assumes one 40 MHz core clock and byte-wide registers on a plain strobe port
`default_nettype none
package pin_io_pkg;
    // register addresses
    localparam logic [7:0] ADDR_PIN_IO_CONTROL = 8'h27;
    localparam logic [7:0] ADDR_PIN_FUNCTION = 8'h40;
    localparam logic [7:0] ADDR_CAPTURE_MODE = 8'h41;
    localparam logic [7:0] ADDR_IRQ_A_SOURCE_MASK = 8'h42;
    localparam logic [7:0] ADDR_PIN_STATUS = 8'h43;
    // pin_io_control fields
    localparam int IRQ_A_MODE_LSB = 0;
    localparam int EVENT_MODE_LSB = 2;
    localparam int EVENT_TYPE_BIT = 4;
    localparam int POLARITY_BIT = 5;
    localparam int PULLUP_SEL_BIT = 6;
    localparam int CLK_PIN_OFF_BIT = 7;
    // pin_function fields
    localparam int FREQ_SEL_LSB = 0;
    localparam int HALT_EN_BIT = 3;
    localparam int SOFT_STOP_BIT = 4;
    // capture_mode fields
    localparam int CAPTURE2_LSB = 0;
    localparam int CAPTURE1_LSB = 3;
    // pin_status fields
    localparam int STAT_BATTERY_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_HALTED_BIT = 2;
    localparam int STAT_SAMPLE_BIT = 3;
    // reset values and the static frequency code
    localparam logic [7:0] PIN_IO_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PIN_FUNCTION_RESET = 8'h00;
    localparam logic [7:0] CAPTURE_MODE_RESET = 8'h00;
    localparam logic [7:0] IRQ_A_SOURCE_MASK_RESET = 8'h00;
    localparam logic [2:0] FREQ_STATIC = 3'h7;
    // timing
    localparam int CORE_CLK_HZ = 40_000_000;
    localparam int SWITCH_SAMPLE_HZ = 16;
    localparam int SAMPLE_WINDOW_NS = 30_500;
    localparam int SAMPLE_WINDOW_CYCLES = (SAMPLE_WINDOW_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {
        EVENT_DISABLED = 2'b00,
        EVENT_IRQ_B_OUT = 2'b01,
        EVENT_CLOCK_OUT = 2'b10,
        EVENT_INPUT = 2'b11
    } event_pin_mode_t;

    typedef enum logic [1:0] {
        IRQ_A_CLOCK = 2'b00,
        IRQ_A_BATTERY = 2'b01,
        IRQ_A_DATA = 2'b10,
        IRQ_A_HIZ = 2'b11
    } irq_a_pin_mode_t;
endpackage
`default_nettype wire

// file: rtl/pin_sync3.sv
// pin_sync3: three-stage synchroniser per bit, output changes once stages two and three agree
// assumes asynchronous inputs and one core clock
`default_nettype none
module pin_sync3 #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic stage2_reg;
            logic stage3_reg;
            logic level_reg;
            // first stage is read by the second stage only
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    meta_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                    stage3_reg <= 1'b0;
                end else begin
                    meta_reg <= pin_in[i];
                    stage2_reg <= meta_reg;
                    stage3_reg <= stage2_reg;
                end
            end
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    level_reg <= 1'b0;
                end else if (stage2_reg == stage3_reg) begin
                    level_reg <= stage3_reg;
                end
            end
            // two processes per bit write its own flops, the vector is only assembled here
            assign level_out[i] = level_reg;
        end
    endgenerate
endmodule // pin_sync3
`default_nettype wire

// file: rtl/rtc_pin_io_control.sv
// rtc_pin_io_control: event pin and irq pin a function select with event input conditioning
// assumes byte registers on a strobe port, clock taps and irq sources from same-clock logic
`default_nettype none
module rtc_pin_io_control #(
    parameter int SAMPLE_PERIOD_CYCLES = pin_io_pkg::CORE_CLK_HZ / pin_io_pkg::SWITCH_SAMPLE_HZ,
    parameter logic [1:0] CAPTURE1_PIN_CODE = 2'h1,
    parameter logic [2:0] CAPTURE2_PIN_CODE = 3'h1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic on_battery_in,
    input wire logic [6:0] freq_taps,
    input wire logic irq_line_b_n,
    input wire logic [7:0] irq_a_sources,
    input wire logic event_pin_in,
    output logic event_pin_out,
    output logic event_pin_oe,
    output logic switch_pullup_en,
    output logic switch_pullup_strong,
    output logic irq_pin_a_out,
    output logic irq_pin_a_oe,
    output logic clk_pin_disable,
    output logic event_pulse,
    output logic capture1_trigger,
    output logic capture2_trigger,
    output logic counting_halted
);
    logic [7:0] pin_io_control_reg;
    logic [7:0] pin_function_reg;
    logic [7:0] capture_mode_reg;
    logic [7:0] irq_a_source_mask_reg;
    logic [1:0] sync_level;
    logic ev_level;
    logic on_battery;
    pin_io_pkg::event_pin_mode_t event_pin_mode;
    pin_io_pkg::irq_a_pin_mode_t irq_a_pin_mode;
    logic event_input_type;
    logic event_pin_polarity;
    logic switch_pullup_select;
    logic [2:0] clock_out_freq_sel;
    logic pin_halt_enable;
    logic soft_stop;
    logic [2:0] capture2_source_mode;
    logic [1:0] capture1_source_mode;
    logic sel_clock;
    logic [31:0] sample_cnt_reg;
    logic sample_run;
    logic sampled_reg;
    logic active_next;
    logic active_reg;
    logic halt_next;

    assign event_pin_mode = pin_io_pkg::event_pin_mode_t'(pin_io_control_reg[pin_io_pkg::EVENT_MODE_LSB +: 2]);
    assign irq_a_pin_mode = pin_io_pkg::irq_a_pin_mode_t'(pin_io_control_reg[pin_io_pkg::IRQ_A_MODE_LSB +: 2]);
    assign event_input_type = pin_io_control_reg[pin_io_pkg::EVENT_TYPE_BIT];
    assign event_pin_polarity = pin_io_control_reg[pin_io_pkg::POLARITY_BIT];
    assign switch_pullup_select = pin_io_control_reg[pin_io_pkg::PULLUP_SEL_BIT];
    assign clk_pin_disable = pin_io_control_reg[pin_io_pkg::CLK_PIN_OFF_BIT];
    assign clock_out_freq_sel = pin_function_reg[pin_io_pkg::FREQ_SEL_LSB +: 3];
    assign pin_halt_enable = pin_function_reg[pin_io_pkg::HALT_EN_BIT];
    assign soft_stop = pin_function_reg[pin_io_pkg::SOFT_STOP_BIT];
    assign capture2_source_mode = capture_mode_reg[pin_io_pkg::CAPTURE2_LSB +: 3];
    assign capture1_source_mode = capture_mode_reg[pin_io_pkg::CAPTURE1_LSB +: 2];

    // pin and supply levels come from outside the clock domain
    pin_sync3 #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in({on_battery_in, event_pin_in}),
        .level_out(sync_level)
    );
    assign ev_level = sync_level[0];
    assign on_battery = sync_level[1];

    // register writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_io_control_reg <= pin_io_pkg::PIN_IO_CONTROL_RESET;
            pin_function_reg <= pin_io_pkg::PIN_FUNCTION_RESET;
            capture_mode_reg <= pin_io_pkg::CAPTURE_MODE_RESET;
            irq_a_source_mask_reg <= pin_io_pkg::IRQ_A_SOURCE_MASK_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                pin_io_pkg::ADDR_PIN_IO_CONTROL: pin_io_control_reg <= reg_wdata;
                pin_io_pkg::ADDR_PIN_FUNCTION: pin_function_reg <= {3'h0, reg_wdata[4:0]};
                pin_io_pkg::ADDR_CAPTURE_MODE: capture_mode_reg <= {3'h0, reg_wdata[4:0]};
                pin_io_pkg::ADDR_IRQ_A_SOURCE_MASK: irq_a_source_mask_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped addresses
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                pin_io_pkg::ADDR_PIN_IO_CONTROL: reg_rdata <= pin_io_control_reg;
                pin_io_pkg::ADDR_PIN_FUNCTION: reg_rdata <= pin_function_reg;
                pin_io_pkg::ADDR_CAPTURE_MODE: reg_rdata <= capture_mode_reg;
                pin_io_pkg::ADDR_IRQ_A_SOURCE_MASK: reg_rdata <= irq_a_source_mask_reg;
                pin_io_pkg::ADDR_PIN_STATUS: reg_rdata <= {4'h0, sampled_reg, counting_halted,
                                                          active_reg, on_battery};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // selected clock tap; static low when the frequency select is the top code
    assign sel_clock = (clock_out_freq_sel == pin_io_pkg::FREQ_STATIC) ? 1'b0 : freq_taps[clock_out_freq_sel];

    // switch detector runs only in input mode with the switch type chosen
    assign sample_run = (event_pin_mode == pin_io_pkg::EVENT_INPUT) && event_input_type;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_cnt_reg <= 32'h0000_0000;
        end else if (!sample_run) begin
            sample_cnt_reg <= 32'h0000_0000;
        end else if (sample_cnt_reg == 32'(SAMPLE_PERIOD_CYCLES - 1)) begin
            sample_cnt_reg <= 32'h0000_0000;
        end else begin
            sample_cnt_reg <= sample_cnt_reg + 32'h0000_0001;
        end
    end

    // pull-up only inside the window keeps a closed switch from drawing current all the time
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            switch_pullup_en <= 1'b0;
            switch_pullup_strong <= 1'b0;
        end else begin
            switch_pullup_en <= sample_run && (sample_cnt_reg < 32'(pin_io_pkg::SAMPLE_WINDOW_CYCLES));
            switch_pullup_strong <= sample_run && switch_pullup_select;
        end
    end

    // level taken at the last cycle of the window, once the pull-up has settled the pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sampled_reg <= 1'b0;
        end else if (sample_run && sample_cnt_reg == 32'(pin_io_pkg::SAMPLE_WINDOW_CYCLES)) begin
            sampled_reg <= ev_level;
        end
    end

    // active level: direct input is dead on battery, switch detector works on any supply
    always_comb begin
        active_next = 1'b0;
        if (event_pin_mode == pin_io_pkg::EVENT_INPUT) begin
            if (event_input_type) begin
                active_next = sampled_reg ^ event_pin_polarity;
            end else if (!on_battery) begin
                active_next = ev_level ^ event_pin_polarity;
            end
        end
    end

    // stop follows software stop, or the active pin level when halt enable allows it
    assign halt_next = soft_stop || (pin_halt_enable && active_next);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            active_reg <= 1'b0;
            event_pulse <= 1'b0;
            capture1_trigger <= 1'b0;
            capture2_trigger <= 1'b0;
            counting_halted <= 1'b0;
        end else begin
            active_reg <= active_next;
            event_pulse <= active_next && !active_reg;
            capture1_trigger <= active_next && !active_reg && capture1_source_mode == CAPTURE1_PIN_CODE;
            capture2_trigger <= active_next && !active_reg && capture2_source_mode == CAPTURE2_PIN_CODE;
            counting_halted <= halt_next;
        end
    end

    // event pin drive; both output modes release the pin on battery
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            event_pin_out <= 1'b0;
            event_pin_oe <= 1'b0;
        end else begin
            case (event_pin_mode)
                pin_io_pkg::EVENT_IRQ_B_OUT: begin
                    event_pin_out <= irq_line_b_n;
                    event_pin_oe <= !on_battery;
                end
                pin_io_pkg::EVENT_CLOCK_OUT: begin
                    event_pin_out <= sel_clock;
                    event_pin_oe <= !on_battery;
                end
                default: begin
                    event_pin_out <= 1'b0;
                    event_pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // irq pin a is open drain: output low, enable means pulling low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_pin_a_out <= 1'b0;
            irq_pin_a_oe <= 1'b0;
        end else begin
            irq_pin_a_out <= 1'b0;
            case (irq_a_pin_mode)
                pin_io_pkg::IRQ_A_CLOCK: begin
                    irq_pin_a_oe <= !on_battery && clock_out_freq_sel != pin_io_pkg::FREQ_STATIC
                                    && !sel_clock;
                end
                pin_io_pkg::IRQ_A_BATTERY: irq_pin_a_oe <= on_battery;
                pin_io_pkg::IRQ_A_DATA: irq_pin_a_oe <= |(irq_a_sources & irq_a_source_mask_reg);
                default: irq_pin_a_oe <= 1'b0;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_window_open;
        $rose(switch_pullup_en);
    endsequence
    sequence s_window_hold;
        switch_pullup_en [*8];
    endsequence

    edge_polarity_a: assert property (event_pulse |-> $past(active_next) && !$past(active_reg))
        else $error("event pulse without active transition");
    single_pulse_a: assert property (event_pulse |=> !event_pulse)
        else $error("event pulse longer than one cycle");
    halt_follow_a: assert property ((pin_halt_enable && event_pin_mode == pin_io_pkg::EVENT_INPUT
                                     && active_next) |=> counting_halted)
        else $error("pin active but counting not halted");
    disabled_hiz_a: assert property (event_pin_mode == pin_io_pkg::EVENT_DISABLED |=> !event_pin_oe)
        else $error("disabled event pin driven");
    irqb_battery_a: assert property ((event_pin_mode == pin_io_pkg::EVENT_IRQ_B_OUT && on_battery)
                                     |=> !event_pin_oe)
        else $error("irq b driven on battery");
    clk_out_a: assert property ((event_pin_mode == pin_io_pkg::EVENT_CLOCK_OUT && !on_battery)
                                |=> event_pin_oe && event_pin_out == $past(sel_clock))
        else $error("clock out not driven on main supply");
    type_ignored_a: assert property (event_pin_mode != pin_io_pkg::EVENT_INPUT |=> !switch_pullup_en)
        else $error("pull-up active outside input mode");
    direct_battery_a: assert property ((event_pin_mode == pin_io_pkg::EVENT_INPUT && !event_input_type
                                        && on_battery) |-> !active_next)
        else $error("direct input active on battery");
    window_len_a: assert property ((s_window_open ##0 sample_run) |-> s_window_hold)
        else $error("sample window too short");
    pullup_strength_a: assert property (switch_pullup_en |-> switch_pullup_strong == $past(switch_pullup_select))
        else $error("pull-up strength does not follow select");
    capture_trigger_a: assert property ((active_next && !active_reg
                                         && capture1_source_mode == CAPTURE1_PIN_CODE) |=> capture1_trigger)
        else $error("capture not triggered by pin event");
    battery_ind_a: assert property (irq_a_pin_mode == pin_io_pkg::IRQ_A_BATTERY
                                    |=> irq_pin_a_oe == $past(on_battery))
        else $error("battery indication wrong");
    irqa_clock_a: assert property ((irq_a_pin_mode == pin_io_pkg::IRQ_A_CLOCK && on_battery) |=> !irq_pin_a_oe)
        else $error("clock on pin a while on battery");
    irqa_data_a: assert property (irq_a_pin_mode == pin_io_pkg::IRQ_A_DATA
                                  |=> irq_pin_a_oe == $past(|(irq_a_sources & irq_a_source_mask_reg)))
        else $error("irq data on pin a wrong");
endmodule // rtc_pin_io_control
`default_nettype wire

// file: verification/pin_far_side.sv
// pin_far_side: event pin wire with outside driver and mechanical switch, pulled-up irq a line
// assumes the block's pad controls and the core clock
`default_nettype none
module pin_far_side (
    input wire logic core_clk,
    input wire logic event_pin_out,
    input wire logic event_pin_oe,
    input wire logic switch_pullup_en,
    input wire logic irq_pin_a_oe,
    input wire logic drive_en,
    input wire logic drive_level,
    input wire logic switch_closed,
    output logic event_pin_in,
    output logic irq_a_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_reg = 1'b0;
    // nothing holds an undriven wire, so its level changes every cycle
    always @(posedge core_clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        if (event_pin_oe) begin
            event_pin_in = event_pin_out;
        end else if (drive_en) begin
            event_pin_in = drive_level;
        end else if (switch_closed) begin
            event_pin_in = 1'b0;
        end else if (switch_pullup_en) begin
            event_pin_in = 1'b1;
        end else begin
            event_pin_in = float_reg;
        end
    end
    // open drain: board pull-up wins unless the block pulls low
    assign irq_a_level = irq_pin_a_oe ? 1'b0 : 1'b1;
endmodule // pin_far_side
`default_nettype wire

// file: verification/tb_top.sv
// tb_top: self-checking bench for rtc_pin_io_control, table of pin modes then event cases
// assumes pin_io_pkg and a shortened switch sample period
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, reg_wr, reg_rd, on_battery_in, irq_line_b_n, event_pin_in;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_a_sources;
    logic [6:0] freq_taps;
    logic event_pin_out, event_pin_oe, switch_pullup_en, switch_pullup_strong, irq_pin_a_out, irq_pin_a_oe;
    logic clk_pin_disable, event_pulse, capture1_trigger, capture2_trigger, counting_halted;
    logic drive_en, drive_level, switch_closed, irq_a_level, clr_cnt;
    int bad_count = 0, num_checks = 0, ev_cnt = 0, c1_cnt = 0, c2_cnt = 0, cycles = 0, run;
    typedef struct {
        logic [7:0] io, fn, mask, src;
        int batt;
        logic [6:0] taps;
        int irqb_n, ev_oe, ev_out, a_low;
    } row_t;
    row_t rows[20] = '{
        '{8'h00, 8'h00, 8'h00, 8'h00, 0, 7'h00, 1, 0, 0, 1}, '{8'h00, 8'h00, 8'h00, 8'h00, 0, 7'h01, 1, 0, 0, 0},
        '{8'h00, 8'h00, 8'h00, 8'h00, 1, 7'h00, 1, 0, 0, 0}, '{8'h00, 8'h07, 8'h00, 8'h00, 0, 7'h00, 1, 0, 0, 0},
        '{8'h01, 8'h00, 8'h00, 8'h00, 0, 7'h00, 1, 0, 0, 0}, '{8'h01, 8'h00, 8'h00, 8'h00, 1, 7'h7F, 1, 0, 0, 1},
        '{8'h02, 8'h00, 8'h01, 8'h01, 0, 7'h7F, 1, 0, 0, 1}, '{8'h02, 8'h00, 8'h01, 8'h01, 1, 7'h7F, 1, 0, 0, 1},
        '{8'h02, 8'h00, 8'h00, 8'h01, 0, 7'h7F, 1, 0, 0, 0}, '{8'h03, 8'h00, 8'h00, 8'h00, 0, 7'h00, 1, 0, 0, 0},
        '{8'h07, 8'h00, 8'h00, 8'h00, 0, 7'h7F, 0, 1, 0, 0}, '{8'h07, 8'h00, 8'h00, 8'h00, 0, 7'h7F, 1, 1, 1, 0},
        '{8'h07, 8'h00, 8'h00, 8'h00, 1, 7'h7F, 0, 0, 0, 0}, '{8'h17, 8'h00, 8'h00, 8'h00, 0, 7'h7F, 0, 1, 0, 0},
        '{8'h0B, 8'h00, 8'h00, 8'h00, 0, 7'h01, 1, 1, 1, 0}, '{8'h0B, 8'h00, 8'h00, 8'h00, 0, 7'h00, 1, 1, 0, 0},
        '{8'h0B, 8'h02, 8'h00, 8'h00, 0, 7'h04, 1, 1, 1, 0}, '{8'h0B, 8'h00, 8'h00, 8'h00, 1, 7'h7F, 1, 0, 0, 0},
        '{8'h0B, 8'h07, 8'h00, 8'h00, 0, 7'h7F, 1, 1, 0, 0}, '{8'h0F, 8'h00, 8'h00, 8'h00, 0, 7'h7F, 1, 0, 0, 0}};

    rtc_pin_io_control #(.SAMPLE_PERIOD_CYCLES(2000)) u_rtc_pin_io_control (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .on_battery_in(on_battery_in), .freq_taps(freq_taps), .irq_line_b_n(irq_line_b_n),
        .irq_a_sources(irq_a_sources), .event_pin_in(event_pin_in), .event_pin_out(event_pin_out),
        .event_pin_oe(event_pin_oe), .switch_pullup_en(switch_pullup_en),
        .switch_pullup_strong(switch_pullup_strong), .irq_pin_a_out(irq_pin_a_out),
        .irq_pin_a_oe(irq_pin_a_oe), .clk_pin_disable(clk_pin_disable), .event_pulse(event_pulse),
        .capture1_trigger(capture1_trigger), .capture2_trigger(capture2_trigger),
        .counting_halted(counting_halted));
    pin_far_side u_pin_far_side (.core_clk(core_clk), .event_pin_out(event_pin_out),
        .event_pin_oe(event_pin_oe), .switch_pullup_en(switch_pullup_en), .irq_pin_a_oe(irq_pin_a_oe),
        .drive_en(drive_en), .drive_level(drive_level), .switch_closed(switch_closed),
        .event_pin_in(event_pin_in), .irq_a_level(irq_a_level));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        ev_cnt <= clr_cnt ? 0 : ev_cnt + (event_pulse === 1'b1);
        c1_cnt <= clr_cnt ? 0 : c1_cnt + (capture1_trigger === 1'b1);
        c2_cnt <= clr_cnt ? 0 : c2_cnt + (capture2_trigger === 1'b1);
        cycles <= cycles + 1;
        // whole run needs about 10k cycles
        if (cycles == 40000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            bad_count++;
            $display("[ERR] %0t count got %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk8(reg_rdata, exp);
    endtask
    // waits n edges, then lands mid-cycle so register updates have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        on_battery_in = 1'b0; freq_taps = 7'h7F; irq_line_b_n = 1'b1; irq_a_sources = 8'h00;
        drive_en = 1'b1; drive_level = 1'b0; switch_closed = 1'b0; clr_cnt = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        cyc(1);
        chk1(event_pin_oe, 1'b0);
        rd(pin_io_pkg::ADDR_PIN_IO_CONTROL, pin_io_pkg::PIN_IO_CONTROL_RESET);
        wr(pin_io_pkg::ADDR_PIN_IO_CONTROL, 8'hFF);
        rd(pin_io_pkg::ADDR_PIN_IO_CONTROL, 8'hFF);
        chk1(clk_pin_disable, 1'b1);
        wr(pin_io_pkg::ADDR_PIN_FUNCTION, 8'hFF);
        rd(pin_io_pkg::ADDR_PIN_FUNCTION, 8'h1F);
        rd(8'h50, 8'h00);
        end_test("registers");
        foreach (rows[i]) begin
            wr(pin_io_pkg::ADDR_PIN_IO_CONTROL, rows[i].io);
            wr(pin_io_pkg::ADDR_PIN_FUNCTION, rows[i].fn);
            wr(pin_io_pkg::ADDR_IRQ_A_SOURCE_MASK, rows[i].mask);
            on_battery_in <= rows[i].batt[0];
            freq_taps <= rows[i].taps;
            irq_line_b_n <= rows[i].irqb_n[0];
            irq_a_sources <= rows[i].src;
            cyc(8);
            chk1(event_pin_oe, rows[i].ev_oe[0]);
            if (rows[i].ev_oe != 0) chk1(event_pin_out, rows[i].ev_out[0]);
            chk1(irq_a_level, !rows[i].a_low[0]);
            chk1(irq_pin_a_out, 1'b0);
        end
        end_test("pin mode table");
        wr(pin_io_pkg::ADDR_CAPTURE_MODE, 8'h09);
        on_battery_in <= 1'b0;
        rd(pin_io_pkg::ADDR_CAPTURE_MODE, 8'h09);
        wr(pin_io_pkg::ADDR_PIN_FUNCTION, 8'h08);
        for (int p = 0; p < 2; p++) begin
            wr(pin_io_pkg::ADDR_PIN_IO_CONTROL, p ? 8'h2F : 8'h0F);
            drive_level <= p[0];
            cyc(8);
            clr_cnt <= 1'b1;
            @(posedge core_clk);
            clr_cnt <= 1'b0;
            drive_level <= ~p[0];
            cyc(8);
            chkn(ev_cnt, 1);
            chkn(c1_cnt, 1);
            chkn(c2_cnt, 1);
            chk1(counting_halted, 1'b1);
            @(posedge core_clk);
            drive_level <= p[0];
            cyc(8);
            chkn(ev_cnt, 1);
            chk1(counting_halted, 1'b0);
        end
        wr(pin_io_pkg::ADDR_PIN_FUNCTION, 8'h10);
        cyc(3);
        chk1(counting_halted, 1'b1);
        rd(pin_io_pkg::ADDR_PIN_STATUS, 8'h04);
        end_test("direct input");
        wr(pin_io_pkg::ADDR_CAPTURE_MODE, 8'h00);
        wr(pin_io_pkg::ADDR_PIN_FUNCTION, 8'h00);
        on_battery_in <= 1'b1;
        cyc(8);
        rd(pin_io_pkg::ADDR_PIN_STATUS, 8'h01);
        clr_cnt <= 1'b1;
        @(posedge core_clk);
        clr_cnt <= 1'b0;
        drive_level <= 1'b0;
        cyc(8);
        @(posedge core_clk);
        drive_level <= 1'b1;
        cyc(8);
        chkn(ev_cnt, 0);
        chkn(c1_cnt, 0);
        wr(pin_io_pkg::ADDR_PIN_IO_CONTROL, 8'h03);
        drive_en <= 1'b0;
        cyc(40);
        chkn(ev_cnt, 0);
        chk1(event_pin_oe, 1'b0);
        end_test("ignored inputs");
        // switch mode on battery: pull-up window of 1220 cycles in each 2000
        wr(pin_io_pkg::ADDR_PIN_IO_CONTROL, 8'h5F);
        switch_closed <= 1'b1;
        run = 0;
        // sampled mid-cycle so each window cycle is counted once
        while (switch_pullup_en !== 1'b1 && run < 2100) begin
            cyc(0);
            run++;
        end
        run = 0;
        while (switch_pullup_en === 1'b1 && run < 2100) begin
            cyc(0);
            run++;
        end
        chkn(run, 1220);
        chk1(switch_pullup_strong, 1'b1);
        cyc(2100);
        clr_cnt <= 1'b1;
        @(posedge core_clk);
        clr_cnt <= 1'b0;
        switch_closed <= 1'b0;
        cyc(4200);
        chkn(ev_cnt, 1);
        wr(pin_io_pkg::ADDR_PIN_IO_CONTROL, 8'h1F);
        cyc(2100);
        chk1(switch_pullup_strong, 1'b0);
        end_test("switch detector");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        cyc(1);
        chk1(switch_pullup_en, 1'b0);
        chk1(counting_halted, 1'b0);
        rd(pin_io_pkg::ADDR_PIN_IO_CONTROL, pin_io_pkg::PIN_IO_CONTROL_RESET);
        end_test("mid-run reset");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
